// File: rxe_pkg.sv
// Purpose: Shared constants and types for the receive event latch and milliwatt block
// Assumes: 8-bit register port, 100 MHz system clock, T1 frame of 125 us
// Notes:   Latched bits clear by writing one; a new event in the same cycle wins
package rxe_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_CH = 24;

  typedef logic [ADDR_W-1:0] rxe_addr_t;
  typedef logic [DATA_W-1:0] rxe_byte_t;

  // Register offsets
  localparam rxe_addr_t OFF_MW_CH1_8   = 8'h3c;
  localparam rxe_addr_t OFF_MW_CH9_16  = 8'h3d;
  localparam rxe_addr_t OFF_MW_CH17_24 = 8'h3e;
  localparam rxe_addr_t OFF_SCE_ONE    = 8'h40;
  localparam rxe_addr_t OFF_SCE_TWO    = 8'h41;
  localparam rxe_addr_t OFF_SCE_THREE  = 8'h42;
  localparam rxe_addr_t OFF_ERR_CFG    = 8'h86;
  localparam rxe_addr_t OFF_LAT_THREE  = 8'h92;
  localparam rxe_addr_t OFF_LAT_TIMING = 8'h93;
  localparam rxe_addr_t OFF_LAT_LINK   = 8'h96;
  localparam rxe_addr_t OFF_MSK_CLOCK  = 8'ha2;
  localparam rxe_addr_t OFF_MSK_TIMING = 8'ha3;
  localparam rxe_addr_t OFF_MSK_LINK   = 8'ha6;

  // Reset value of every register
  localparam rxe_byte_t RST_BYTE = 8'h00;

  // Implemented widths of the latched groups
  localparam int LAT3_W = 8;
  localparam int LAT4_W = 4;
  localparam int LAT7_W = 6;

  // Field positions, clock and loop code group
  localparam int B3_LOSS_CLR  = 7;
  localparam int B3_SPARE_CLR = 6;
  localparam int B3_DOWN_CLR  = 5;
  localparam int B3_UP_CLR    = 4;
  localparam int B3_LOSS_DET  = 3;
  localparam int B3_SPARE_DET = 2;
  localparam int B3_DOWN_DET  = 1;
  localparam int B3_UP_DET    = 0;
  // Field positions, timing group
  localparam int B4_SIGCHG = 3;
  localparam int B4_ONESEC = 2;
  localparam int B4_TIMER  = 1;
  localparam int B4_MF     = 0;
  // Field positions, link code group
  localparam int B7_RAI_CI = 5;
  localparam int B7_AIS_CI = 4;
  localparam int B7_SLC    = 3;
  localparam int B7_FDL    = 2;
  localparam int B7_BC     = 1;
  localparam int B7_BD     = 0;
  // Update select inside the error counter configuration
  localparam int B_UPD_SEL = 4;

  // Timing
  localparam int SYS_PERIOD_NS = 10;
  localparam int CHAN_TIME_NS  = 5182;
  localparam int LOSS_CYC      = (CHAN_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int FRAME_US      = 125;
  localparam int ONE_SEC_US    = 1000000;
  localparam int UPD_T1_US     = 42000;
  localparam int UPD_E1_US     = 62500;
  localparam int MF_D4_US      = 1500;
  localparam int MF_ESF_US     = 3000;
  localparam int FR_ONE_SEC    = ONE_SEC_US / FRAME_US;
  localparam int FR_UPD_T1     = UPD_T1_US / FRAME_US;
  localparam int FR_UPD_E1     = UPD_E1_US / FRAME_US;
  localparam int FR_MF_D4      = MF_D4_US / FRAME_US;
  localparam int FR_MF_ESF     = MF_ESF_US / FRAME_US;
  localparam int BITS_T1       = 193;
  localparam int BITS_E1       = 256;

  // Digital milliwatt sequence, first byte in the top lane
  localparam logic [63:0] MW_SEQ = 64'h1e0b0b1e9e8b8b9e;

  // One receive channel byte
  typedef struct packed {
    logic       valid;
    logic [4:0] index;
    rxe_byte_t  data;
  } rxe_chan_t;

  // Conditions and pulses from the framer's detectors
  typedef struct packed {
    logic spare_code;
    logic loop_down;
    logic loop_up;
    logic remote_alarm;
    logic alarm_ind;
    logic rai_ci_seen;
    logic ais_ci_seen;
    logic slc_align;
    logic datalink_full;
    logic boc_valid;
  } rxe_detect_t;

endpackage

// File: rxe_sticky_bank.sv
// Purpose: Bank of sticky event bits with write-one-to-clear
// Assumes: Set pulses and clear come from the sys_clk domain
// Notes:   A set in the same cycle as a clear keeps the bit set
`timescale 1ns/100ps
module rxe_sticky_bank
  import rxe_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] set_ev,
  input  wire logic         clr_we,
  input  wire logic [W-1:0] clr_bits,
  output logic      [W-1:0] status
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // Set has priority so no event is lost to a racing clear
      always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
          status[i] <= 1'b0;
        end else if (set_ev[i]) begin
          status[i] <= 1'b1;
        end else if (clr_we && clr_bits[i]) begin
          status[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// File: rxe_top.sv
// Purpose: Receive latched events, interrupt masks and per-channel milliwatt insertion
// Assumes: Detector inputs and modes are synchronous to sys_clk; line clock is a pin
// Notes:   Timers run from the receive line clock, so they halt while it is lost
// Notes on behaviour
// [RULE1] Mask bit zero blocks, one passes event
// [RULE2] Third mask: clock, spare, down, up enables
// [RULE3] Clock loss after one silent channel time
// [RULE4] Fourth status: four latched interrupting events
// [RULE5] Software writes zero to upper four bits
// [RULE6] Enabled channel signaling change latches event
// [RULE7] One-second event from receive line clock
// [RULE8] Timer event at selected counter update interval
// [RULE9] Multiframe event every 1.5 or 3 ms
// [RULE10] Seventh status: six latched interrupting events
// [RULE11] RAI-CI latches only in ESF with RAI
// [RULE12] RAI-CI relatches on each new detection
// [RULE13] AIS-CI latches during AIS, held until cleared
// [RULE14] SLC-96 alignment with data ready latches event
// [RULE15] Datalink holding register full latches event
// [RULE16] Filtered bit-oriented code loss latches event
// [RULE17] Filtered bit-oriented code detection latches event
// [RULE18] Fourth mask: one enable per event
// [RULE19] Seventh mask: six enables, upper zero
// [RULE20] Channels 1-8 replaced by milliwatt when set
// [RULE21] Channels 9-16 replaced by milliwatt when set
// [RULE22] Channels 17-24 replaced by milliwatt when set
// [RULE23] Interrupt while any unmasked latched event pending
`timescale 1ns/100ps
module rxe_top
  import rxe_pkg::*;
#(
  parameter int FRAMES_PER_SEC = FR_ONE_SEC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire rxe_addr_t   reg_addr,
  input  wire rxe_byte_t   reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output rxe_byte_t        reg_rdata,
  input  wire logic        rx_line_clk_pin,
  input  wire logic        e1_mode,
  input  wire logic        esf_mode,
  input  wire rxe_detect_t det,
  input  wire logic [23:0] sig_state_changed,
  input  wire rxe_chan_t   chan_in,
  output rxe_chan_t        chan_out,
  output logic             irq
);

  // Register write decode
  wire wr_mw1  = reg_wr && (reg_addr == OFF_MW_CH1_8);
  wire wr_mw2  = reg_wr && (reg_addr == OFF_MW_CH9_16);
  wire wr_mw3  = reg_wr && (reg_addr == OFF_MW_CH17_24);
  wire wr_sce1 = reg_wr && (reg_addr == OFF_SCE_ONE);
  wire wr_sce2 = reg_wr && (reg_addr == OFF_SCE_TWO);
  wire wr_sce3 = reg_wr && (reg_addr == OFF_SCE_THREE);
  wire wr_cfg  = reg_wr && (reg_addr == OFF_ERR_CFG);
  wire wr_lat3 = reg_wr && (reg_addr == OFF_LAT_THREE);
  wire wr_lat4 = reg_wr && (reg_addr == OFF_LAT_TIMING);
  wire wr_lat7 = reg_wr && (reg_addr == OFF_LAT_LINK);
  wire wr_msk3 = reg_wr && (reg_addr == OFF_MSK_CLOCK);
  wire wr_msk4 = reg_wr && (reg_addr == OFF_MSK_TIMING);
  wire wr_msk7 = reg_wr && (reg_addr == OFF_MSK_LINK);

  // Control registers
  logic [23:0]       mw_en_r;
  logic [23:0]       sce_r;
  logic              upd_sel_r;
  logic [LAT3_W-1:0] msk3_r;
  logic [LAT4_W-1:0] msk4_r;
  logic [LAT7_W-1:0] msk7_r;

  // Plain storage; unused upper bits of narrow masks are dropped
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      mw_en_r   <= {3{RST_BYTE}};
      sce_r     <= {3{RST_BYTE}};
      upd_sel_r <= 1'b0;
      msk3_r    <= RST_BYTE;
      msk4_r    <= RST_BYTE[LAT4_W-1:0];
      msk7_r    <= RST_BYTE[LAT7_W-1:0];
    end else begin
      if (wr_mw1)  mw_en_r[7:0]   <= reg_wdata;               // [RULE20]
      if (wr_mw2)  mw_en_r[15:8]  <= reg_wdata;               // [RULE21]
      if (wr_mw3)  mw_en_r[23:16] <= reg_wdata;               // [RULE22]
      if (wr_sce1) sce_r[7:0]     <= reg_wdata;
      if (wr_sce2) sce_r[15:8]    <= reg_wdata;
      if (wr_sce3) sce_r[23:16]   <= reg_wdata;
      if (wr_cfg)  upd_sel_r      <= reg_wdata[B_UPD_SEL];
      if (wr_msk3) msk3_r         <= reg_wdata;               // [RULE2]
      if (wr_msk4) msk4_r         <= reg_wdata[LAT4_W-1:0];   // [RULE18] [RULE5]
      if (wr_msk7) msk7_r         <= reg_wdata[LAT7_W-1:0];   // [RULE19]
    end
  end

  // Line clock synchroniser; the first stage feeds only the second
  logic lclk_s1_r;
  logic lclk_s2_r;
  logic lclk_s3_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      lclk_s1_r <= 1'b0;
      lclk_s2_r <= 1'b0;
      lclk_s3_r <= 1'b0;
    end else begin
      lclk_s1_r <= rx_line_clk_pin;
      lclk_s2_r <= lclk_s1_r;
      lclk_s3_r <= lclk_s2_r;
    end
  end

  wire lclk_toggle = lclk_s2_r ^ lclk_s3_r;
  wire lclk_rise   = lclk_s2_r & ~lclk_s3_r;

  // Clock loss: count system cycles since the last line clock transition
  localparam logic [9:0] LOSS_LIMIT = 10'(LOSS_CYC);
  logic [9:0] silent_cnt_r;
  logic       loss_cond_r;
  wire        silent_full = (silent_cnt_r == LOSS_LIMIT);
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      silent_cnt_r <= '0;
      loss_cond_r  <= 1'b0;
    end else begin
      silent_cnt_r <= lclk_toggle ? 10'h000 : (silent_full ? silent_cnt_r : silent_cnt_r + 10'h001);
      loss_cond_r  <= silent_full && !lclk_toggle;            // [RULE3]
    end
  end

  // Previous condition levels for edge detection
  logic loss_q_r;
  logic spare_q_r;
  logic down_q_r;
  logic up_q_r;
  logic boc_q_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      loss_q_r  <= 1'b0;
      spare_q_r <= 1'b0;
      down_q_r  <= 1'b0;
      up_q_r    <= 1'b0;
      boc_q_r   <= 1'b0;
    end else begin
      loss_q_r  <= loss_cond_r;
      spare_q_r <= det.spare_code;
      down_q_r  <= det.loop_down;
      up_q_r    <= det.loop_up;
      boc_q_r   <= det.boc_valid;
    end
  end

  // Frame timing from line clock edges
  localparam logic [8:0]  BITS_T1_LAST = 9'(BITS_T1 - 1);
  localparam logic [8:0]  BITS_E1_LAST = 9'(BITS_E1 - 1);
  localparam logic [13:0] SEC_LAST     = 14'(FRAMES_PER_SEC - 1);
  localparam logic [13:0] UPD_T1_LAST  = 14'(FR_UPD_T1 - 1);
  localparam logic [13:0] UPD_E1_LAST  = 14'(FR_UPD_E1 - 1);
  localparam logic [4:0]  MF_D4_LAST   = 5'(FR_MF_D4 - 1);
  localparam logic [4:0]  MF_ESF_LAST  = 5'(FR_MF_ESF - 1);

  logic [8:0]  bit_cnt_r;
  logic [13:0] sec_cnt_r;
  logic [13:0] upd_cnt_r;
  logic [4:0]  mf_cnt_r;
  wire  [8:0]  bit_last  = e1_mode ? BITS_E1_LAST : BITS_T1_LAST;
  wire         frame_end = lclk_rise && (bit_cnt_r == bit_last);
  wire         sec_end   = frame_end && (sec_cnt_r == SEC_LAST);                  // [RULE7]
  wire  [13:0] upd_fast  = e1_mode ? UPD_E1_LAST : UPD_T1_LAST;
  wire         upd_end   = upd_sel_r ? (frame_end && (upd_cnt_r == upd_fast)) : sec_end; // [RULE8]
  wire  [4:0]  mf_last   = esf_mode ? MF_ESF_LAST : MF_D4_LAST;
  wire         mf_end    = frame_end && (mf_cnt_r >= mf_last);                    // [RULE9]

  // Bit, second, update and multiframe counters
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      bit_cnt_r <= '0;
      sec_cnt_r <= '0;
      upd_cnt_r <= '0;
      mf_cnt_r  <= '0;
    end else if (lclk_rise) begin
      bit_cnt_r <= frame_end ? 9'h000 : bit_cnt_r + 9'h001;
      if (frame_end) begin
        sec_cnt_r <= sec_end ? 14'h0000 : sec_cnt_r + 14'h0001;
        upd_cnt_r <= (upd_end || upd_cnt_r >= upd_fast) ? 14'h0000 : upd_cnt_r + 14'h0001;
        mf_cnt_r  <= mf_end ? 5'h00 : mf_cnt_r + 5'h01;
      end
    end
  end

  // Event sources per latched group
  wire [LAT3_W-1:0] set3;
  wire [LAT4_W-1:0] set4;
  wire [LAT7_W-1:0] set7;
  assign set3[B3_LOSS_CLR]  = loss_q_r & ~loss_cond_r;        // [RULE3]
  assign set3[B3_SPARE_CLR] = spare_q_r & ~det.spare_code;
  assign set3[B3_DOWN_CLR]  = down_q_r & ~det.loop_down;
  assign set3[B3_UP_CLR]    = up_q_r & ~det.loop_up;
  assign set3[B3_LOSS_DET]  = loss_cond_r & ~loss_q_r;        // [RULE3]
  assign set3[B3_SPARE_DET] = det.spare_code & ~spare_q_r;
  assign set3[B3_DOWN_DET]  = det.loop_down & ~down_q_r;
  assign set3[B3_UP_DET]    = det.loop_up & ~up_q_r;
  assign set4[B4_SIGCHG]    = |(sig_state_changed & sce_r);   // [RULE6]
  assign set4[B4_ONESEC]    = sec_end;                        // [RULE7]
  assign set4[B4_TIMER]     = upd_end;                        // [RULE8]
  assign set4[B4_MF]        = mf_end;                         // [RULE9]
  assign set7[B7_RAI_CI]    = det.rai_ci_seen && esf_mode && det.remote_alarm; // [RULE11] [RULE12]
  assign set7[B7_AIS_CI]    = det.ais_ci_seen && det.alarm_ind;                // [RULE13]
  assign set7[B7_SLC]       = det.slc_align;                  // [RULE14]
  assign set7[B7_FDL]       = det.datalink_full;              // [RULE15]
  assign set7[B7_BC]        = boc_q_r & ~det.boc_valid;       // [RULE16]
  assign set7[B7_BD]        = det.boc_valid & ~boc_q_r;       // [RULE17]

  // Latched status groups
  logic [LAT3_W-1:0] lat3;
  logic [LAT4_W-1:0] lat4;
  logic [LAT7_W-1:0] lat7;

  rxe_sticky_bank #(.W(LAT3_W)) u_lat3 (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .set_ev   (set3),
    .clr_we   (wr_lat3),
    .clr_bits (reg_wdata),
    .status   (lat3)
  );

  rxe_sticky_bank #(.W(LAT4_W)) u_lat4 (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .set_ev   (set4),
    .clr_we   (wr_lat4),
    .clr_bits (reg_wdata[LAT4_W-1:0]),                         // [RULE4]
    .status   (lat4)
  );

  rxe_sticky_bank #(.W(LAT7_W)) u_lat7 (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .set_ev   (set7),
    .clr_we   (wr_lat7),
    .clr_bits (reg_wdata[LAT7_W-1:0]),                         // [RULE10]
    .status   (lat7)
  );

  // Masked pending events; a zero mask bit blocks its event
  wire pending = |(lat3 & msk3_r) | |(lat4 & msk4_r) | |(lat7 & msk7_r); // [RULE1] [RULE4] [RULE10]

  logic irq_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) irq_r <= 1'b0;
    else        irq_r <= pending;                             // [RULE23]
  end
  assign irq = irq_r;

  // Read mux; unmapped offsets and unused bits read zero
  rxe_byte_t rd_mux;
  always_comb begin
    unique case (reg_addr)
      OFF_MW_CH1_8:   rd_mux = mw_en_r[7:0];
      OFF_MW_CH9_16:  rd_mux = mw_en_r[15:8];
      OFF_MW_CH17_24: rd_mux = mw_en_r[23:16];
      OFF_SCE_ONE:    rd_mux = sce_r[7:0];
      OFF_SCE_TWO:    rd_mux = sce_r[15:8];
      OFF_SCE_THREE:  rd_mux = sce_r[23:16];
      OFF_ERR_CFG:    rd_mux = 8'(upd_sel_r) << B_UPD_SEL;
      OFF_LAT_THREE:  rd_mux = lat3;
      OFF_LAT_TIMING: rd_mux = {4'h0, lat4};
      OFF_LAT_LINK:   rd_mux = {2'h0, lat7};
      OFF_MSK_CLOCK:  rd_mux = msk3_r;
      OFF_MSK_TIMING: rd_mux = {4'h0, msk4_r};
      OFF_MSK_LINK:   rd_mux = {2'h0, msk7_r};
      default:        rd_mux = RST_BYTE;
    endcase
  end

  // Read data stands for the one cycle after the strobe
  rxe_byte_t rdata_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_b)      rdata_r <= RST_BYTE;
    else if (reg_rd) rdata_r <= rd_mux;
    else             rdata_r <= RST_BYTE;
  end
  assign reg_rdata = rdata_r;

  // Milliwatt phase steps once per frame so each channel sees the full sequence
  localparam logic [4:0] LAST_CH = 5'(NUM_CH - 1);
  logic [2:0] mw_phase_r;
  wire        ch_en    = mw_en_r[chan_in.index];
  wire [5:0]  mw_shift = {(3'h7 - mw_phase_r), 3'h0};
  wire [7:0]  mw_byte  = 8'(MW_SEQ >> mw_shift);

  // Replace data of enabled channels; others pass unchanged
  rxe_chan_t chan_out_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      mw_phase_r <= 3'h0;
      chan_out_r <= '0;
    end else begin
      if (chan_in.valid && chan_in.index == LAST_CH) mw_phase_r <= mw_phase_r + 3'h1;
      chan_out_r.valid <= chan_in.valid;
      chan_out_r.index <= chan_in.index;
      chan_out_r.data  <= ch_en ? mw_byte : chan_in.data;     // [RULE20] [RULE21] [RULE22]
    end
  end
  assign chan_out = chan_out_r;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_irq_follows_mask: assert property (irq == $past(pending))                           // [RULE1]
    else $error("irq does not follow masked pending events");
  a_irq_masked_off: assert property ((lat7 & msk7_r) == 0 && (lat3 & msk3_r) == 0 && (lat4 & msk4_r) == 0
                                     |=> !irq)                                            // [RULE23]
    else $error("irq raised with all events masked");
  a_loss_detect: assert property ($rose(loss_cond_r) |=> lat3[B3_LOSS_DET])              // [RULE3]
    else $error("clock loss detect not latched");
  a_loss_timing: assert property (lclk_toggle |-> ##1 !loss_cond_r [*8])                   // [RULE3]
    else $error("clock loss declared too early");
  a_upper_zero: assert property (rd_mux[7:4] == 4'h0 || reg_addr != OFF_MSK_TIMING)        // [RULE5]
    else $error("upper bits of fourth mask not zero");
  a_sig_change: assert property (|(sig_state_changed & sce_r) |=> lat4[B4_SIGCHG])        // [RULE6]
    else $error("signaling change not latched");
  a_rai_gate: assert property (det.rai_ci_seen && !(esf_mode && det.remote_alarm) && !lat7[B7_RAI_CI]
                               |=> !lat7[B7_RAI_CI])                                      // [RULE11]
    else $error("RAI-CI latched outside ESF remote alarm");
  a_ais_hold: assert property (lat7[B7_AIS_CI] && !(wr_lat7 && reg_wdata[B7_AIS_CI])
                               |=> lat7[B7_AIS_CI])                                       // [RULE13]
    else $error("AIS-CI dropped without host clear");
  a_boc_clear: assert property ($fell(det.boc_valid) |=> lat7[B7_BC])                     // [RULE16]
    else $error("code clear not latched");
  a_mw_replace: assert property (chan_in.valid && ch_en |=> chan_out.data == $past(mw_byte)) // [RULE20]
    else $error("enabled channel not replaced");
  a_mw_pass: assert property (chan_in.valid && !ch_en |=> chan_out.data == $past(chan_in.data)) // [RULE21]
    else $error("disabled channel altered");
  a_mf_spacing: assert property (mf_end |=> !mf_end [*8])                                  // [RULE9]
    else $error("multiframe events too close");

  c_irq_raised: cover property ($rose(irq));
  c_loss_then_back: cover property (lat3[B3_LOSS_DET] ##[1:1000] lat3[B3_LOSS_CLR]);
  c_mw_insert: cover property (chan_in.valid && ch_en);
  c_set_beats_clear: cover property (wr_lat7 && reg_wdata[B7_BD] && set7[B7_BD]);

endmodule

// File: rxe_host.sv
// Purpose: Host model on the register port
// Assumes: One-cycle strobes, read data in the cycle after
// Notes:   wr zeroes unused upper bits of timing and link registers, wr_raw does not
`timescale 1ns/100ps
module rxe_host
  import rxe_pkg::*;
(
  input  wire logic      sys_clk,
  output rxe_addr_t      reg_addr,
  output rxe_byte_t      reg_wdata,
  output logic           reg_wr,
  output logic           reg_rd,
  input  wire rxe_byte_t reg_rdata
);
  // Idle bus at time zero
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One write cycle; data inverted once released
  task automatic wr_raw(input rxe_addr_t a, input rxe_byte_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // Unused upper bits of the timing and link registers always go out as zero
  task automatic wr(input rxe_addr_t a, input rxe_byte_t d);
    wr_raw(a, d & ((a == OFF_LAT_TIMING || a == OFF_MSK_TIMING) ? 8'h0f :
      (a == OFF_LAT_LINK || a == OFF_MSK_LINK) ? 8'h3f : 8'hff));
  endtask
  // Read data stands one cycle only, taken at that edge
  task automatic rd(input rxe_addr_t a, output rxe_byte_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask
endmodule

// File: rxe_top_bench.sv
// Purpose: Self-checking bench for rxe_top
// Assumes: Line clock of 4 sys cycles, four frames per second
// Notes:   Timer periods are judged by spacing of irq rises
`timescale 1ns/100ps
module rxe_top_bench
  import rxe_pkg::*;
;
  localparam int FPS = 4;  // Short second keeps the run brief
  localparam int LCP = 4;  // Line clock period in sys cycles
  logic        sys_clk, rst_b, lclk, lc_on, e1_mode, esf_mode, reg_wr, reg_rd, irq;
  rxe_addr_t   reg_addr;
  rxe_byte_t   reg_wdata, reg_rdata, v;
  rxe_detect_t det;
  rxe_chan_t   chan_in, chan_out;
  logic [23:0] sig_chg, mw;
  // Milliwatt byte expected at phase p, first byte in the top lane
  function automatic rxe_byte_t mw_exp(input int p);
    return MW_SEQ[63 - 8*p -: 8];
  endfunction
  int          n_mismatch, n_checks, cyc, t0, t1, ph, c;
  rxe_addr_t   ra[14] = '{OFF_MW_CH1_8, OFF_MW_CH9_16, OFF_MW_CH17_24, OFF_SCE_ONE, OFF_SCE_TWO, OFF_SCE_THREE,
    OFF_ERR_CFG, OFF_LAT_THREE, OFF_LAT_TIMING, OFF_LAT_LINK, OFF_MSK_CLOCK, OFF_MSK_TIMING, OFF_MSK_LINK, 8'h00};
  rxe_addr_t   mk[3] = '{OFF_MSK_CLOCK, OFF_MSK_TIMING, OFF_MSK_LINK};
  rxe_byte_t   mke[3] = '{8'hff, 8'h0f, 8'h3f};

  rxe_top #(.FRAMES_PER_SEC(FPS)) DUT (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_line_clk_pin(lclk),
    .e1_mode(e1_mode), .esf_mode(esf_mode), .det(det), .sig_state_changed(sig_chg), .chan_in(chan_in),
    .chan_out(chan_out), .irq(irq));
  rxe_host host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // System clock, 100 MHz
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Line clock holds its level while lc_on is low
  initial begin
    lclk = 1'b0;
    forever #(LCP * 5) if (lc_on) lclk = ~lclk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic pulse(input int k);
    @(posedge sys_clk);
    det[k] <= 1'b1;
    @(posedge sys_clk);
    det[k] <= 1'b0;
  endtask
  // Latched, masked off, enabled, then cleared by writing one
  task automatic latch_chk(input rxe_addr_t lat, input rxe_addr_t msk, input int b);
    repeat (3) @(posedge sys_clk);
    host.rd(lat, v);
    chk("latched", 1, v[b]);
    chk("irq masked", 0, irq);
    host.wr(msk, 8'h01 << b);
    repeat (2) @(posedge sys_clk);
    chk("irq enabled", 1, irq);
    host.wr(lat, 8'h01 << b);
    host.rd(lat, v);
    chk("cleared", 0, v[b]);
    chk("irq idle", 0, irq);
    host.wr(msk, 8'h00);
  endtask
  // Bounded wait; polled just after each edge
  task automatic wait_irq(input logic lv, output int t);
    int n;
    n = 0;
    while (irq !== lv && n < 40000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("irq wait", lv, irq);
    t = cyc;
  endtask
  // Spacing of two successive events of one timing bit
  task automatic meas(input int b, input int exp);
    host.wr(OFF_MSK_TIMING, 8'h00);
    host.wr(OFF_LAT_TIMING, 8'h0f);
    host.wr(OFF_MSK_TIMING, 8'h01 << b);
    wait_irq(1'b1, t0);
    host.wr(OFF_LAT_TIMING, 8'h01 << b);
    wait_irq(1'b0, t1);
    wait_irq(1'b1, t1);
    chk("interval", exp, t1 - t0);
    host.wr(OFF_MSK_TIMING, 8'h00);
  endtask

  // Watchdog at 100k cycles, above the expected run of about 74k cycles
  initial begin
    #1000000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    rst_b = 1'b0;
    lc_on = 1'b1;
    e1_mode = 1'b0;
    esf_mode = 1'b0;
    det = '0;
    sig_chg = '0;
    chan_in = '0;
    c = $urandom(32'h3ad8f727);
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    foreach (ra[i]) begin
      host.rd(ra[i], v);
      chk("reset value", RST_BYTE, v);
    end
    for (int i = 0; i < 3; i++) begin
      host.wr(mk[i], 8'hff);
      host.rd(mk[i], v);
      chk("mask bits", mke[i], v);
      host.wr(mk[i], 8'h00);
    end
    host.wr(OFF_ERR_CFG, 8'h10);
    host.rd(OFF_ERR_CFG, v);
    chk("update select", 8'h10, v);
    host.wr(OFF_ERR_CFG, 8'h00);
    $display("test registers done");
    mw = 24'($urandom);
    for (int r = 0; r < 3; r++) begin
      host.wr(rxe_addr_t'(OFF_MW_CH1_8 + r), mw[r*8 +: 8]);
      host.rd(rxe_addr_t'(OFF_MW_CH1_8 + r), v);
      chk("mw enable", mw[r*8 +: 8], v);
    end
    ph = 0;
    for (int k = 0; k < 72; k++) begin
      @(posedge sys_clk);
      chan_in <= '{1'b1, 5'(k % 24), 8'($urandom)};
      @(posedge sys_clk);
      chan_in.valid <= 1'b0;
      #1;
      chk("chan", {1'b1, 5'(k % 24), mw[k % 24] ? mw_exp(ph) : chan_in.data}, chan_out);
      if (k % 24 == 23) ph = (ph + 1) % 8;
    end
    $display("test milliwatt done");
    @(posedge sys_clk);
    // ESF off: a seen pattern must not latch
    det.remote_alarm <= 1'b1;
    pulse(4);
    host.rd(OFF_LAT_LINK, v);
    chk("rai outside esf", 0, v[B7_RAI_CI]);
    esf_mode <= 1'b1;
    pulse(4);
    latch_chk(OFF_LAT_LINK, OFF_MSK_LINK, B7_RAI_CI);
    pulse(4);
    latch_chk(OFF_LAT_LINK, OFF_MSK_LINK, B7_RAI_CI);
    pulse(3);
    host.rd(OFF_LAT_LINK, v);
    chk("ais no alarm", 0, v[B7_AIS_CI]);
    det.alarm_ind <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      pulse(3);
      latch_chk(OFF_LAT_LINK, OFF_MSK_LINK, B7_AIS_CI);
    end
    pulse(2);
    latch_chk(OFF_LAT_LINK, OFF_MSK_LINK, B7_SLC);
    pulse(1);
    latch_chk(OFF_LAT_LINK, OFF_MSK_LINK, B7_FDL);
    det.boc_valid <= 1'b1;
    latch_chk(OFF_LAT_LINK, OFF_MSK_LINK, B7_BD);
    det.boc_valid <= 1'b0;
    latch_chk(OFF_LAT_LINK, OFF_MSK_LINK, B7_BC);
    $display("test link events done");
    for (int k = 0; k < 3; k++) begin
      det[9-k] <= 1'b1;
      latch_chk(OFF_LAT_THREE, OFF_MSK_CLOCK, B3_SPARE_DET - k);
      det[9-k] <= 1'b0;
      latch_chk(OFF_LAT_THREE, OFF_MSK_CLOCK, B3_SPARE_CLR - k);
    end
    // Only channel c enabled; its neighbour changes first
    c = $urandom_range(23);
    host.wr(rxe_addr_t'(OFF_SCE_ONE + c / 8), 8'h01 << (c % 8));
    @(posedge sys_clk);
    sig_chg <= 24'h1 << ((c + 1) % 24);
    @(posedge sys_clk);
    sig_chg <= '0;
    host.rd(OFF_LAT_TIMING, v);
    chk("change not enabled", 0, v[B4_SIGCHG]);
    sig_chg <= 24'h1 << c;
    @(posedge sys_clk);
    sig_chg <= '0;
    latch_chk(OFF_LAT_TIMING, OFF_MSK_TIMING, B4_SIGCHG);
    $display("test code events done");
    lc_on = 1'b0;
    repeat (420) @(posedge sys_clk);
    host.rd(OFF_LAT_THREE, v);
    chk("loss too early", 0, v[B3_LOSS_DET]);
    repeat (180) @(posedge sys_clk);
    latch_chk(OFF_LAT_THREE, OFF_MSK_CLOCK, B3_LOSS_DET);
    lc_on = 1'b1;
    repeat (10) @(posedge sys_clk);
    latch_chk(OFF_LAT_THREE, OFF_MSK_CLOCK, B3_LOSS_CLR);
    $display("test clock loss done");
    esf_mode <= 1'b0;
    meas(B4_ONESEC, FPS * BITS_T1 * LCP);
    meas(B4_TIMER, FPS * BITS_T1 * LCP);
    meas(B4_MF, FR_MF_D4 * BITS_T1 * LCP);
    esf_mode <= 1'b1;
    meas(B4_MF, FR_MF_ESF * BITS_T1 * LCP);
    e1_mode <= 1'b1;
    meas(B4_ONESEC, FPS * BITS_E1 * LCP);
    $display("test timers done");
    print_verdict();
  end
endmodule
